//--- logic/fpp_defines.svh
// Purpose: constants for the four pin port
// Assumes: 50 MHz system clock
// Notes:   reset values of direction, latch and analog select
`ifndef FPP_DEFINES_SVH
`define FPP_DEFINES_SVH
`define FPP_BIDIR_W        3
`define FPP_DIR_RST        3'h7
`define FPP_LAT_RST        3'h0
`define FPP_ANA_RST        3'h7
`define FPP_PSP_RST        4'h0
`define FPP_DIR_LO_POS     0
`define FPP_PSP_POS        4
`define FPP_SYNC_RST       4'h8
`endif

//--- logic/fpp_pkg.sv
// Purpose: types for the four pin port
// Assumes: nothing
// Notes:   package variant selection
package fpp_pkg;
   typedef enum logic [1:0] {
      FPP_LARGE_type_val = 2'h1,
      FPP_SMALL_type_val = 2'h2
   } fpp_variant_type;
endpackage : fpp_pkg

//--- logic/fpp_sync.sv
// Purpose: two flop synchroniser for pin inputs
// Assumes: single clock domain
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
`default_nettype none
module fpp_sync #(
   parameter int           W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   input  wire logic [W-1:0]  i_async,
   output logic      [W-1:0]  o_sync
);
   if (W < 1)
   begin : g_bad_width
      $error("fpp_sync: width must be at least one");
   end

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end
   assign o_sync = sync_ff;
endmodule : fpp_sync
`default_nettype wire

//--- logic/fpp_port.sv
// Purpose: four pin port, three bidirectional pins plus input-only pin
// Assumes: config bits static after reset; plain write strobes
// Notes:   pins are split into in, out and output enable
`timescale 1ns/100ps
`default_nettype none
`include "fpp_defines.svh"
module fpp_port
   import fpp_pkg::*;
#(
   parameter fpp_variant_type VARIANT = FPP_LARGE_type_val
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_external_reset_pin_enable,
   input  wire logic [7:0]  i_dir_wdata,
   input  wire logic        i_dir_we,
   input  wire logic [2:0]  i_lat_wdata,
   input  wire logic        i_lat_we,
   input  wire logic [2:0]  i_ana_wdata,
   input  wire logic        i_ana_we,
   input  wire logic [3:0]  i_psp_status,
   input  wire logic [2:0]  i_bidir_pin_in,
   input  wire logic        i_fourth_pin_in,
   output logic      [2:0]  o_bidir_pin_out,
   output logic      [2:0]  o_bidir_pin_oe,
   output logic      [7:0]  o_dir_rdata,
   output logic      [2:0]  o_lat_rdata,
   output logic      [3:0]  o_port_rdata,
   output logic      [3:0]  o_psp_ctrl,
   output logic             o_external_reset_req
);
   // ************************************************
   // elaboration checks
   // ************************************************
   if (VARIANT != FPP_LARGE_type_val && VARIANT != FPP_SMALL_type_val)
   begin : g_bad_variant
      $error("fpp_port: unsupported variant");
   end

   localparam logic HAS_BIDIR = (VARIANT == FPP_LARGE_type_val);

   // small variant has no bidirectional pins: their out, enable and port bits stay zero
   function automatic logic [2:0] bidir_gate(input logic [2:0] val);
      return HAS_BIDIR ? val : 3'h0;
   endfunction : bidir_gate

   // ************************************************
   // pin synchronisers
   // ************************************************
   // fourth pin starts at its idle high level;
   // a low start value would fake a reset request after release
   logic [3:0] pins_sync;
   fpp_sync #(.W(4), .RST_VAL(`FPP_SYNC_RST)) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async ({i_fourth_pin_in, i_bidir_pin_in}),
      .o_sync  (pins_sync)
   );

   // ************************************************
   // registers
   // ************************************************
   logic [2:0] dir_ff;
   logic [3:0] psp_ff;
   logic [2:0] lat_ff;
   logic [2:0] ana_ff;
   logic       cfg_rst_en_ff;

   // strap caught after release, not under reset
   // strap is static wiring, so it needs no synchroniser
   logic strap_done_ff;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         strap_done_ff <= 1'h0;
         cfg_rst_en_ff <= 1'h1;
      end
      else if (!strap_done_ff)
      begin
         strap_done_ff <= 1'h1;
         cfg_rst_en_ff <= i_external_reset_pin_enable;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         dir_ff <= `FPP_DIR_RST;
      else if (i_dir_we && HAS_BIDIR)
         dir_ff <= i_dir_wdata[`FPP_DIR_LO_POS +: 3];
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         psp_ff <= `FPP_PSP_RST;
      else if (i_dir_we && HAS_BIDIR)
         psp_ff <= i_dir_wdata[`FPP_PSP_POS +: 4];
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         lat_ff <= `FPP_LAT_RST;
      else if (i_lat_we && HAS_BIDIR)
         lat_ff <= i_lat_wdata;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ana_ff <= `FPP_ANA_RST;
      else if (i_ana_we && HAS_BIDIR)
         ana_ff <= i_ana_wdata;
   end

   // ************************************************
   // pin drive and readback
   // ************************************************
   // analog select does not touch drivers; software keeps them inputs
   logic [2:0] nxt_oe;
   logic [3:0] nxt_port;
   always_comb
   begin
      nxt_oe = bidir_gate(~dir_ff);
      nxt_port[2:0] = bidir_gate(pins_sync[2:0] & ~ana_ff);
      nxt_port[3] = cfg_rst_en_ff ? 1'h0 : pins_sync[3];
   end

   logic [2:0] pin_out_ff;
   logic [2:0] pin_oe_ff;
   logic [7:0] dir_rd_ff;
   logic [2:0] lat_rd_ff;
   logic [3:0] port_rd_ff;
   logic [3:0] psp_out_ff;
   logic       rst_req_ff;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_out_ff <= `FPP_LAT_RST;
         pin_oe_ff  <= 3'h0;
         dir_rd_ff  <= {`FPP_PSP_RST, 1'h0, `FPP_DIR_RST};
         lat_rd_ff  <= `FPP_LAT_RST;
         port_rd_ff <= 4'h0;
         psp_out_ff <= `FPP_PSP_RST;
         rst_req_ff <= 1'h0;
      end
      else
      begin
         pin_out_ff <= bidir_gate(lat_ff);
         pin_oe_ff  <= nxt_oe;
         dir_rd_ff  <= {psp_ff | i_psp_status, 1'h0, dir_ff};
         lat_rd_ff  <= lat_ff;
         port_rd_ff <= nxt_port;
         psp_out_ff <= psp_ff;
         // active while the reset pin is low and enabled
         rst_req_ff <= cfg_rst_en_ff & ~pins_sync[3];
      end
   end

   assign o_bidir_pin_out      = pin_out_ff;
   assign o_bidir_pin_oe       = pin_oe_ff;
   assign o_dir_rdata          = dir_rd_ff;
   assign o_lat_rdata          = lat_rd_ff;
   assign o_port_rdata         = port_rd_ff;
   assign o_psp_ctrl           = psp_out_ff;
   assign o_external_reset_req = rst_req_ff;

   // ************************************************
   // assertions
   // ************************************************
   dir_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_dir_we && HAS_BIDIR |-> ##2 (o_bidir_pin_oe == ~$past(i_dir_wdata[2:0], 2)))
      else $error("output enable does not follow direction");
   lat_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_lat_we && HAS_BIDIR |-> ##2 (o_bidir_pin_out == $past(i_lat_wdata, 2)))
      else $error("pin output does not follow latch");
   ana_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_port_rdata[2:0] & $past(ana_ff)) == 3'h0)
      else $error("analog pin reads nonzero");
   ana_oe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_bidir_pin_oe == (HAS_BIDIR ? ~$past(dir_ff) : 3'h0))
      else $error("analog select changed driver");
   psp_upper_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_dir_we && HAS_BIDIR |-> ##2 (o_psp_ctrl == $past(i_dir_wdata[7:4], 2)))
      else $error("upper direction bits lost");
   lat_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_lat_rdata == o_bidir_pin_out || !HAS_BIDIR)
      else $error("latch readback differs from latch");
   fourth_in_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !cfg_rst_en_ff |=> (o_port_rdata[3] == $past(pins_sync[3])) && !o_external_reset_req)
      else $error("fourth pin input wrong");
   reset_pin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cfg_rst_en_ff && !pins_sync[3] |=> o_external_reset_req && !o_port_rdata[3])
      else $error("reset pin not honoured");
   small_var_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !HAS_BIDIR |-> o_bidir_pin_oe == 3'h0 && o_port_rdata[2:0] == 3'h0)
      else $error("small variant drives bidir pins");
   lat_back_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_lat_we && HAS_BIDIR |-> ##2 (o_lat_rdata == $past(i_lat_wdata, 2)))
      else $error("latch readback lost a write");
   reset_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $past(!i_rst_n) |-> ##1 (o_bidir_pin_oe == 3'h0 && o_port_rdata[2:0] == 3'h0))
      else $error("pins not inputs and analog after reset");
endmodule : fpp_port
`default_nettype wire

//--- tb/fpp_port_tb_top.sv
// Purpose: self-checking bench for the four pin port
// Assumes: large and small variant side by side; strap steady around each reset
// Notes:   inputs change on the falling edge, outputs read after settling
`timescale 1ns/100ps
`default_nettype none
module fpp_port_tb_top
   import fpp_pkg::*;
();
   logic        i_clk;
   logic        i_rst_n;
   logic        i_external_reset_pin_enable;
   logic [7:0]  i_dir_wdata;
   logic        i_dir_we;
   logic [2:0]  i_lat_wdata;
   logic        i_lat_we;
   logic [2:0]  i_ana_wdata;
   logic        i_ana_we;
   logic [3:0]  i_psp_status;
   logic [2:0]  i_bidir_pin_in;
   logic        i_fourth_pin_in;
   logic [2:0]  o_bidir_pin_out;
   logic [2:0]  o_bidir_pin_oe;
   logic [7:0]  o_dir_rdata;
   logic [2:0]  o_lat_rdata;
   logic [3:0]  o_port_rdata;
   logic [3:0]  o_psp_ctrl;
   logic        o_external_reset_req;
   logic [2:0]  s_oe;
   logic [2:0]  s_lat_rd;
   logic [3:0]  s_port;
   logic        s_req;
   int          n_mismatch;
   int          tests_run;
   int          cyc;

   fpp_port #(.VARIANT(FPP_LARGE_type_val)) dut_u (.i_clk, .i_rst_n,
      .i_external_reset_pin_enable, .i_dir_wdata, .i_dir_we, .i_lat_wdata, .i_lat_we,
      .i_ana_wdata, .i_ana_we, .i_psp_status, .i_bidir_pin_in, .i_fourth_pin_in,
      .o_bidir_pin_out, .o_bidir_pin_oe, .o_dir_rdata, .o_lat_rdata, .o_port_rdata,
      .o_psp_ctrl, .o_external_reset_req);

   // small variant on the same stimulus: writes refused, bidir bits dead
   fpp_port #(.VARIANT(FPP_SMALL_type_val)) dut_small_u (.i_clk, .i_rst_n,
      .i_external_reset_pin_enable, .i_dir_wdata, .i_dir_we, .i_lat_wdata, .i_lat_we,
      .i_ana_wdata, .i_ana_we, .i_psp_status, .i_bidir_pin_in, .i_fourth_pin_in,
      .o_bidir_pin_out (), .o_bidir_pin_oe (s_oe), .o_dir_rdata (),
      .o_lat_rdata (s_lat_rd), .o_port_rdata (s_port), .o_psp_ctrl (),
      .o_external_reset_req (s_req));

   // ************************************************************
   // clock, timeout and tasks
   // ************************************************************
   initial
   begin
      i_clk = 1'h0;
      forever #10 i_clk = ~i_clk;
   end

   // a hang still ends in the one closing report
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // strap must be steady before release, it is sampled right after
   task automatic do_reset(input logic strap);
      @(negedge i_clk);
      i_rst_n = 1'h0;
      i_external_reset_pin_enable = strap;
      repeat (10) @(negedge i_clk);
      i_rst_n = 1'h1;
      repeat (4) @(negedge i_clk);
   endtask : do_reset

   // sel 0 direction, 1 latch, 2 analog select; waits out the two edge answer
   task automatic wr(input int sel, input logic [7:0] d);
      i_dir_wdata = d;
      i_lat_wdata = d[2:0];
      i_ana_wdata = d[2:0];
      i_dir_we    = (sel == 0);
      i_lat_we    = (sel == 1);
      i_ana_we    = (sel == 2);
      @(negedge i_clk);
      {i_dir_we, i_lat_we, i_ana_we} = 3'h0;
      repeat (3) @(negedge i_clk);
   endtask : wr

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      {i_rst_n, i_dir_we, i_lat_we, i_ana_we} = 4'h0;
      {i_dir_wdata, i_lat_wdata, i_ana_wdata} = 14'h0;
      i_psp_status    = 4'h0;
      i_bidir_pin_in  = 3'h7;
      i_fourth_pin_in = 1'h0;
      i_external_reset_pin_enable = 1'h1;
      do_reset(1'h1);
      chk("oe", 8'h00, {5'h0, o_bidir_pin_oe});
      chk("dir_rd", 8'h07, o_dir_rdata);
      chk("port", 8'h00, {4'h0, o_port_rdata});
      chk("rst_req", 8'h01, {7'h0, o_external_reset_req});
      chk("s_port", 8'h00, {4'h0, s_port});
      chk("s_rst_req", 8'h01, {7'h0, s_req});
      i_fourth_pin_in = 1'h1;
      repeat (4) @(negedge i_clk);
      chk("rst_req", 8'h00, {7'h0, o_external_reset_req});
      chk("port", 8'h00, {4'h0, o_port_rdata});
      wr(2, 8'h00);
      wr(1, 8'h05);
      wr(0, 8'hF0);
      chk("oe", 8'h07, {5'h0, o_bidir_pin_oe});
      chk("pin_out", 8'h05, {5'h0, o_bidir_pin_out});
      chk("psp_ctrl", 8'h0F, {4'h0, o_psp_ctrl});
      chk("dir_rd", 8'hF0, o_dir_rdata);
      chk("port", 8'h07, {4'h0, o_port_rdata});
      chk("s_oe", 8'h00, {5'h0, s_oe});
      chk("s_lat_rd", 8'h00, {5'h0, s_lat_rd});
      i_psp_status = 4'h3;
      wr(0, 8'h5E);
      chk("dir_rd", 8'h76, o_dir_rdata);
      chk("oe", 8'h01, {5'h0, o_bidir_pin_oe});
      wr(2, 8'h06);
      chk("oe", 8'h01, {5'h0, o_bidir_pin_oe});
      chk("port", 8'h01, {4'h0, o_port_rdata});
      wr(2, 8'h00);
      i_bidir_pin_in = 3'h2;
      repeat (4) @(negedge i_clk);
      chk("port", 8'h02, {4'h0, o_port_rdata});
      chk("lat_rd", 8'h05, {5'h0, o_lat_rdata});
      wr(1, 8'h02);
      chk("pin_out", 8'h02, {5'h0, o_bidir_pin_out});
      // second reset with the strap low: fourth pin becomes a plain input
      do_reset(1'h0);
      chk("port", 8'h08, {4'h0, o_port_rdata});
      chk("s_port", 8'h08, {4'h0, s_port});
      chk("rst_req", 8'h00, {7'h0, o_external_reset_req});
      chk("lat_rd", 8'h00, {5'h0, o_lat_rdata});
      i_fourth_pin_in = 1'h0;
      repeat (4) @(negedge i_clk);
      chk("port", 8'h00, {4'h0, o_port_rdata});
      chk("s_port", 8'h00, {4'h0, s_port});
      chk("rst_req", 8'h00, {7'h0, o_external_reset_req});
      results();
   end
endmodule : fpp_port_tb_top
`default_nettype wire
